/* core/plc_ctrl_pkg.sv */
// register map, field positions and codes of the register control engine
// assumes a 32-bit Avalon-MM slave with byte addresses, one word per register
package plc_ctrl_pkg;
  localparam int WW = 16; // controller word width
  localparam logic [5:0] OFS_WIN_SEL = 6'h00;
  localparam logic [5:0] OFS_WIN_ECHO = 6'h04;
  localparam logic [5:0] OFS_RPT_PRINT = 6'h08;
  localparam logic [5:0] OFS_BASE_WIN = 6'h0C;
  localparam logic [5:0] OFS_XFER_MODE = 6'h10;
  localparam logic [5:0] OFS_XFER_COUNT = 6'h14;
  localparam logic [5:0] OFS_XFER_CTL_OFS = 6'h18;
  localparam logic [5:0] OFS_XFER_PNL_OFS = 6'h1C;
  localparam logic [5:0] OFS_XFER_BASE = 6'h20;
  localparam logic [5:0] OFS_CTRL_BITS = 6'h24;
  localparam logic [5:0] OFS_MACRO_NUM = 6'h28;
  localparam logic [5:0] OFS_STATUS = 6'h2C;
  // control bit positions
  localparam int B_BL_OFF = 0;
  localparam int B_BL_OFF_CLR = 1;
  localparam int B_BL_ON = 2;
  localparam int B_BL_ON_CLR = 3;
  localparam int B_HARDCOPY = 4;
  localparam int B_MACRO = 5;
  localparam int NBITS = 6;
  // status bit positions
  localparam int S_BACKLIGHT = 0;
  localparam int S_BUSY = 1;
  // transfer mode codes
  localparam logic [WW-1:0] MODE_IDLE = 16'h0000;
  localparam logic [WW-1:0] MODE_CTL_TO_RCP = 16'h0001;
  localparam logic [WW-1:0] MODE_CTL_TO_LOC = 16'h0002;
  localparam logic [WW-1:0] MODE_RCP_TO_CTL = 16'h0003;
  localparam logic [WW-1:0] MODE_LOC_TO_CTL = 16'h0004;
  localparam logic [WW-1:0] CTL_DATA_GAP = 16'h0004; // data follows the 4 control words
  localparam logic [WW-1:0] RESET_WIN = 16'h0000;
  localparam logic RESET_BACKLIGHT = 1'b1;
endpackage

/* core/xfer_if.sv */
// job hand-off between the register engine and the word mover
// assumes both ends share one clock
`timescale 1ns/10ps
`default_nettype none
interface xfer_if;
  logic start;
  logic to_ctl; // 1: panel store to controller
  logic recipe; // 1: recipe store, 0: local_word_store
  logic [15:0] count;
  logic [15:0] ctl_addr;
  logic [15:0] pnl_addr;
  logic busy;
  logic done;
  modport engine (output start, to_ctl, recipe, count, ctl_addr, pnl_addr, input busy, done);
  modport mover (input start, to_ctl, recipe, count, ctl_addr, pnl_addr, output busy, done);
endinterface
`default_nettype wire

/* core/word_mover.sv */
// copies a block of words between controller space and a panel store
// assumes memory ports answer each request with a one-cycle ack
`timescale 1ns/10ps
`default_nettype none
module word_mover (
  input wire logic clock_i,
  input wire logic nrst_i,
  xfer_if.mover xf,
  output logic ctl_req_o,
  output logic ctl_we_o,
  output logic [15:0] ctl_addr_o,
  output logic [15:0] ctl_wdata_o,
  input wire logic [15:0] ctl_rdata_i,
  input wire logic ctl_ack_i,
  output logic sto_req_o,
  output logic sto_we_o,
  output logic sto_recipe_o,
  output logic [15:0] sto_addr_o,
  output logic [15:0] sto_wdata_o,
  input wire logic [15:0] sto_rdata_i,
  input wire logic sto_ack_i
);
  typedef enum logic [1:0] {
    MV_IDLE = 2'b00,
    MV_READ = 2'b01,
    MV_WRITE = 2'b10
  } mv_state_e;
  mv_state_e state_q;
  logic [15:0] left_q;
  logic to_ctl_q;
  logic done_q;
  logic [15:0] data_q;
  wire src_ack = to_ctl_q ? sto_ack_i : ctl_ack_i;
  wire dst_ack = to_ctl_q ? ctl_ack_i : sto_ack_i;
  // requests: read from source, then write to destination
  assign ctl_req_o = (state_q == MV_READ && !to_ctl_q) || (state_q == MV_WRITE && to_ctl_q);
  assign sto_req_o = (state_q == MV_READ && to_ctl_q) || (state_q == MV_WRITE && !to_ctl_q);
  assign ctl_we_o = (state_q == MV_WRITE);
  assign sto_we_o = (state_q == MV_WRITE);
  assign ctl_wdata_o = data_q;
  assign sto_wdata_o = data_q;
  assign xf.busy = (state_q != MV_IDLE);
  assign xf.done = done_q;
  // one word per read/write pair, addresses step after each write
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= MV_IDLE;
      left_q <= 16'h0000;
      to_ctl_q <= 1'b0;
      sto_recipe_o <= 1'b0;
      ctl_addr_o <= 16'h0000;
      sto_addr_o <= 16'h0000;
      data_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        MV_IDLE: begin
          if (xf.start) begin
            left_q <= xf.count;
            to_ctl_q <= xf.to_ctl;
            sto_recipe_o <= xf.recipe;
            ctl_addr_o <= xf.ctl_addr;
            sto_addr_o <= xf.pnl_addr;
            if (xf.count == 16'h0000) done_q <= 1'b1;
            else state_q <= MV_READ;
          end
        end
        MV_READ: begin
          if (src_ack) begin
            data_q <= to_ctl_q ? sto_rdata_i : ctl_rdata_i;
            state_q <= MV_WRITE;
          end
        end
        MV_WRITE: begin
          if (dst_ack) begin
            ctl_addr_o <= ctl_addr_o + 16'h0001;
            sto_addr_o <= sto_addr_o + 16'h0001;
            left_q <= left_q - 16'h0001;
            if (left_q == 16'h0001) begin
              state_q <= MV_IDLE;
              done_q <= 1'b1;
            end else begin
              state_q <= MV_READ;
            end
          end
        end
        default: state_q <= MV_IDLE;
      endcase
    end
  end

  a_start_address: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (xf.start && state_q == MV_IDLE) |=> ctl_addr_o == $past(xf.ctl_addr))
    else $error("controller start address not taken from job");
endmodule // word_mover
`default_nettype wire

/* core/plc_register_control_engine.sv */
// register control engine: window switch, report print, base window report,
// block transfer, backlight control, screen hardcopy and macro launch
// assumes an Avalon-MM master that holds each request until waitrequest is low
`timescale 1ns/10ps
`default_nettype none

module plc_register_control_engine #(
  parameter int NUM_WIN = 256
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [15:0] win_shown_o,
  output logic win_switch_o,
  output logic report_print_o,
  output logic [15:0] report_win_o,
  output logic backlight_o,
  output logic hardcopy_o,
  output logic macro_run_o,
  output logic [15:0] macro_num_o,
  output logic ctl_req_o,
  output logic ctl_we_o,
  output logic [15:0] ctl_addr_o,
  output logic [15:0] ctl_wdata_o,
  input wire logic [15:0] ctl_rdata_i,
  input wire logic ctl_ack_i,
  output logic sto_req_o,
  output logic sto_we_o,
  output logic sto_recipe_o,
  output logic [15:0] sto_addr_o,
  output logic [15:0] sto_wdata_o,
  input wire logic [15:0] sto_rdata_i,
  input wire logic sto_ack_i
);
  localparam logic [15:0] WIN_LIMIT = 16'(NUM_WIN);

  logic ack_q;
  logic [15:0] sel_q;
  logic [15:0] echo_q;
  logic [15:0] win_q;
  logic [15:0] base_q;
  logic switch_q;
  logic prt_q;
  logic [15:0] prt_num_q;
  logic [15:0] mode_q;
  logic [15:0] count_q;
  logic [15:0] ctl_ofs_q;
  logic [15:0] pnl_ofs_q;
  logic [15:0] xbase_q;
  logic [plc_ctrl_pkg::NBITS-1:0] bits_q;
  logic [plc_ctrl_pkg::NBITS-1:0] bits_d;
  logic [15:0] macro_q;
  logic bl_q;
  logic hc_prev_q;
  logic hc_q;
  logic [31:0] rdata_q;

  xfer_if xf ();

  // bus handshake: one wait cycle, then the request completes
  wire bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_q;
  wire wr_en = avs_write_i & ack_q;
  wire rd_load = avs_read_i & ~ack_q;
  wire [15:0] wd = avs_writedata_i[15:0];

  // address decode
  wire hit_sel = wr_en && avs_address_i == plc_ctrl_pkg::OFS_WIN_SEL;
  wire hit_echo = wr_en && avs_address_i == plc_ctrl_pkg::OFS_WIN_ECHO;
  wire hit_rpt = wr_en && avs_address_i == plc_ctrl_pkg::OFS_RPT_PRINT;
  wire hit_mode = wr_en && avs_address_i == plc_ctrl_pkg::OFS_XFER_MODE;
  wire hit_cnt = wr_en && avs_address_i == plc_ctrl_pkg::OFS_XFER_COUNT;
  wire hit_cofs = wr_en && avs_address_i == plc_ctrl_pkg::OFS_XFER_CTL_OFS;
  wire hit_pofs = wr_en && avs_address_i == plc_ctrl_pkg::OFS_XFER_PNL_OFS;
  wire hit_xbase = wr_en && avs_address_i == plc_ctrl_pkg::OFS_XFER_BASE;
  wire hit_bits = wr_en && avs_address_i == plc_ctrl_pkg::OFS_CTRL_BITS;
  wire hit_mac = wr_en && avs_address_i == plc_ctrl_pkg::OFS_MACRO_NUM;

  // window number checks
  wire win_ok = wd < WIN_LIMIT;
  wire do_switch = hit_sel && win_ok && wd != sel_q;
  wire do_print = hit_rpt && win_ok;

  // transfer mode decode
  wire mode_ok = wd >= plc_ctrl_pkg::MODE_CTL_TO_RCP && wd <= plc_ctrl_pkg::MODE_LOC_TO_CTL;
  wire start = hit_mode && mode_ok && !xf.busy;
  assign xf.start = start;
  assign xf.to_ctl = wd == plc_ctrl_pkg::MODE_RCP_TO_CTL
    || wd == plc_ctrl_pkg::MODE_LOC_TO_CTL;
  assign xf.recipe = wd == plc_ctrl_pkg::MODE_CTL_TO_RCP
    || wd == plc_ctrl_pkg::MODE_RCP_TO_CTL;
  assign xf.count = count_q;
  assign xf.ctl_addr = xbase_q + plc_ctrl_pkg::CTL_DATA_GAP + ctl_ofs_q;
  assign xf.pnl_addr = pnl_ofs_q;

  // read data select
  wire [31:0] status_w = {30'h0, xf.busy, bl_q};
  wire [31:0] rd_mux =
    avs_address_i == plc_ctrl_pkg::OFS_WIN_SEL ? {16'h0000, sel_q} :
    avs_address_i == plc_ctrl_pkg::OFS_WIN_ECHO ? {16'h0000, echo_q} :
    avs_address_i == plc_ctrl_pkg::OFS_RPT_PRINT ? {16'h0000, prt_num_q} :
    avs_address_i == plc_ctrl_pkg::OFS_BASE_WIN ? {16'h0000, base_q} :
    avs_address_i == plc_ctrl_pkg::OFS_XFER_MODE ? {16'h0000, mode_q} :
    avs_address_i == plc_ctrl_pkg::OFS_XFER_COUNT ? {16'h0000, count_q} :
    avs_address_i == plc_ctrl_pkg::OFS_XFER_CTL_OFS ? {16'h0000, ctl_ofs_q} :
    avs_address_i == plc_ctrl_pkg::OFS_XFER_PNL_OFS ? {16'h0000, pnl_ofs_q} :
    avs_address_i == plc_ctrl_pkg::OFS_XFER_BASE ? {16'h0000, xbase_q} :
    avs_address_i == plc_ctrl_pkg::OFS_CTRL_BITS ? {26'h0, bits_q} :
    avs_address_i == plc_ctrl_pkg::OFS_MACRO_NUM ? {16'h0000, macro_q} :
    avs_address_i == plc_ctrl_pkg::OFS_STATUS ? status_w : 32'h00000000;

  // control bits: software write wins over the automatic clear
  wire clr_off = bits_q[plc_ctrl_pkg::B_BL_OFF_CLR] && !bl_q;
  wire clr_on = bits_q[plc_ctrl_pkg::B_BL_ON_CLR] && bl_q;
  always_comb begin
    bits_d = bits_q;
    bits_d[plc_ctrl_pkg::B_BL_OFF_CLR] = bits_q[plc_ctrl_pkg::B_BL_OFF_CLR] & ~clr_off;
    bits_d[plc_ctrl_pkg::B_BL_ON_CLR] = bits_q[plc_ctrl_pkg::B_BL_ON_CLR] & ~clr_on;
    if (hit_bits) bits_d = avs_writedata_i[plc_ctrl_pkg::NBITS-1:0];
  end

  // bus acknowledge and read data
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (rd_load) rdata_q <= rd_mux;
    end
  end

  // window switch, echo, report print and base window report
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_q <= plc_ctrl_pkg::RESET_WIN;
      echo_q <= 16'h0000;
      win_q <= plc_ctrl_pkg::RESET_WIN;
      base_q <= plc_ctrl_pkg::RESET_WIN;
      switch_q <= 1'b0;
      prt_q <= 1'b0;
      prt_num_q <= 16'h0000;
    end else begin
      if (hit_sel) sel_q <= wd;
      if (do_switch) win_q <= wd;
      if (do_switch) echo_q <= wd;
      else if (hit_echo) echo_q <= wd;
      switch_q <= do_switch;
      base_q <= win_q;
      prt_q <= do_print;
      if (do_print) prt_num_q <= wd;
    end
  end

  // transfer control block; the done clear yields to a same-cycle write
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= plc_ctrl_pkg::MODE_IDLE;
      count_q <= 16'h0000;
      ctl_ofs_q <= 16'h0000;
      pnl_ofs_q <= 16'h0000;
      xbase_q <= 16'h0000;
      macro_q <= 16'h0000;
    end else begin
      if (hit_mode) mode_q <= wd;
      else if (xf.done) mode_q <= plc_ctrl_pkg::MODE_IDLE;
      if (hit_cnt) count_q <= wd;
      if (hit_cofs) ctl_ofs_q <= wd;
      if (hit_pofs) pnl_ofs_q <= wd;
      if (hit_xbase) xbase_q <= wd;
      if (hit_mac) macro_q <= wd;
    end
  end

  // backlight, hardcopy edge and control bits
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bits_q <= '0;
      bl_q <= plc_ctrl_pkg::RESET_BACKLIGHT;
      hc_prev_q <= 1'b0;
      hc_q <= 1'b0;
    end else begin
      bits_q <= bits_d;
      if (bits_q[plc_ctrl_pkg::B_BL_OFF] || bits_q[plc_ctrl_pkg::B_BL_OFF_CLR]) begin
        bl_q <= 1'b0;
      end else if (bits_q[plc_ctrl_pkg::B_BL_ON] || bits_q[plc_ctrl_pkg::B_BL_ON_CLR]) begin
        bl_q <= 1'b1;
      end
      hc_prev_q <= bits_q[plc_ctrl_pkg::B_HARDCOPY];
      hc_q <= bits_q[plc_ctrl_pkg::B_HARDCOPY] & ~hc_prev_q;
    end
  end

  // outputs
  assign avs_readdata_o = rdata_q;
  assign win_shown_o = win_q;
  assign win_switch_o = switch_q;
  assign report_print_o = prt_q;
  assign report_win_o = prt_num_q;
  assign backlight_o = bl_q;
  assign hardcopy_o = hc_q;
  assign macro_run_o = bits_q[plc_ctrl_pkg::B_MACRO];
  assign macro_num_o = macro_q;

  word_mover u_mover (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .xf(xf),
    .ctl_req_o(ctl_req_o),
    .ctl_we_o(ctl_we_o),
    .ctl_addr_o(ctl_addr_o),
    .ctl_wdata_o(ctl_wdata_o),
    .ctl_rdata_i(ctl_rdata_i),
    .ctl_ack_i(ctl_ack_i),
    .sto_req_o(sto_req_o),
    .sto_we_o(sto_we_o),
    .sto_recipe_o(sto_recipe_o),
    .sto_addr_o(sto_addr_o),
    .sto_wdata_o(sto_wdata_o),
    .sto_rdata_i(sto_rdata_i),
    .sto_ack_i(sto_ack_i)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_switch_shows_window: assert property (
    do_switch |=> win_switch_o && win_shown_o == $past(wd))
    else $error("valid new window word did not switch");
  a_echo_after_switch: assert property (
    win_switch_o |-> echo_q == win_shown_o)
    else $error("window number not echoed");
  a_switch_once: assert property (
    (hit_sel && wd == sel_q) |=> !win_switch_o)
    else $error("switch without change of window word");
  a_print_keeps_win: assert property (
    do_print |=> report_print_o && $stable(win_shown_o))
    else $error("report print changed shown window");
  a_base_follows: assert property (
    $changed(win_shown_o) |=> base_q == $past(win_shown_o))
    else $error("base window word not updated");
  a_mode_cleared: assert property (
    (xf.done && !hit_mode) |=> mode_q == plc_ctrl_pkg::MODE_IDLE)
    else $error("mode word not cleared after transfer");
  a_backlight_off: assert property (
    bits_q[plc_ctrl_pkg::B_BL_OFF] |=> !backlight_o)
    else $error("backlight not switched off");
  a_backlight_on: assert property (
    (bits_q[plc_ctrl_pkg::B_BL_ON] && !bits_q[plc_ctrl_pkg::B_BL_OFF]
      && !bits_q[plc_ctrl_pkg::B_BL_OFF_CLR]) |=> backlight_o)
    else $error("backlight not switched on");
  a_hardcopy_edge: assert property (
    $rose(bits_q[plc_ctrl_pkg::B_HARDCOPY]) |=> hardcopy_o ##1 !hardcopy_o)
    else $error("hardcopy pulse wrong");
  a_invalid_ignored: assert property (
    (hit_sel && !win_ok) |=> !win_switch_o && $stable(win_shown_o))
    else $error("invalid window number acted on");
  a_off_clear_bit: assert property (
    (bits_q[plc_ctrl_pkg::B_BL_OFF_CLR] && !backlight_o && !hit_bits)
      |=> !bits_q[plc_ctrl_pkg::B_BL_OFF_CLR])
    else $error("off control bit not cleared");
  a_on_clear_bit: assert property (
    (bits_q[plc_ctrl_pkg::B_BL_ON_CLR] && backlight_o && !hit_bits)
      |=> !bits_q[plc_ctrl_pkg::B_BL_ON_CLR])
    else $error("on control bit not cleared");
  a_macro_level: assert property (
    hit_bits |=> macro_run_o == $past(avs_writedata_i[plc_ctrl_pkg::B_MACRO]))
    else $error("macro run level does not follow its bit");
  a_xfer_store_sel: assert property (
    start |=> sto_recipe_o == ($past(wd) == plc_ctrl_pkg::MODE_CTL_TO_RCP
      || $past(wd) == plc_ctrl_pkg::MODE_RCP_TO_CTL))
    else $error("transfer store selection wrong");
  a_panel_start: assert property (
    start |=> sto_addr_o == $past(pnl_ofs_q))
    else $error("panel start address not taken from offset word");
  a_mode_starts: assert property (
    start |=> (ctl_req_o || sto_req_o || xf.done))
    else $error("mode write did not start the transfer");
endmodule // plc_register_control_engine
`default_nettype wire

/* verif/plc_mem_model.sv */
// word memory standing in for the controller or a panel store
// assumes req/we/addr/wdata held until the one-cycle ack is seen
`timescale 1ns/10ps
`default_nettype none
module plc_mem_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic bank_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic ack_o
);
  logic [15:0] mem [0:511];
  logic [1:0] dly_q;
  logic [15:0] junk_q;
  wire [8:0] idx = {bank_i, addr_i[7:0]};
  // read data only stand with ack, otherwise a changing pattern
  assign rdata_o = ack_o ? mem[idx] : junk_q;
  // answer after a random wait of 0..3 cycles, a gap after each ack
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      dly_q <= 2'h0;
      junk_q <= 16'hA5A5;
    end else begin
      junk_q <= ~junk_q;
      if (ack_o) begin
        ack_o <= 1'b0;
      end else if (req_i && dly_q == 2'h0) begin
        ack_o <= 1'b1;
        dly_q <= 2'($urandom_range(0, 3));
        if (we_i) begin
          mem[idx] <= wdata_i;
        end
      end else if (req_i) begin
        dly_q <= dly_q - 2'h1;
      end
    end
  end
endmodule // plc_mem_model
`default_nettype wire

/* verif/plc_register_control_engine_tb.sv */
// self-checking bench of the register control engine
// assumes two memory models as controller space and panel stores
`timescale 1ns/10ps
`default_nettype none
module plc_register_control_engine_tb;
  localparam int NW = 16;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wait_o, wsw, rpr, bl, hc, mrun, creq, cwe, cack, sreq, swe, srcp, sack;
  logic [15:0] win, rwin, mnum, ca, cwd, crd, sa, swd, srd;
  int err_total = 0;
  int compares = 0;
  int hc_cnt = 0;
  logic [31:0] rd_q[$];
  logic [15:0] win_q[$];
  logic [15:0] rpt_q[$];
  // clock generation
  always #5 clock_i = ~clock_i;
  plc_register_control_engine #(.NUM_WIN(NW)) i_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .win_shown_o(win), .win_switch_o(wsw),
    .report_print_o(rpr), .report_win_o(rwin), .backlight_o(bl), .hardcopy_o(hc),
    .macro_run_o(mrun), .macro_num_o(mnum), .ctl_req_o(creq), .ctl_we_o(cwe),
    .ctl_addr_o(ca), .ctl_wdata_o(cwd), .ctl_rdata_i(crd), .ctl_ack_i(cack),
    .sto_req_o(sreq), .sto_we_o(swe), .sto_recipe_o(srcp), .sto_addr_o(sa),
    .sto_wdata_o(swd), .sto_rdata_i(srd), .sto_ack_i(sack));
  plc_mem_model i_ctl (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(creq), .we_i(cwe),
    .bank_i(1'b0), .addr_i(ca), .wdata_i(cwd), .rdata_o(crd), .ack_o(cack));
  plc_mem_model i_sto (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(sreq), .we_i(swe),
    .bank_i(srcp), .addr_i(sa), .wdata_i(swd), .rdata_o(srd), .ack_o(sack));
  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one Avalon access, held until waitrequest is low
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    adr <= a;
    wd <= d;
    wr <= we;
    rd <= ~we;
    do begin
      @(posedge clock_i);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wait_o !== 1'b0) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0, q);
  endtask
  // watcher: read data, window and report pulses against the noted queues
  always @(posedge clock_i) begin
    if (rd && wait_o === 1'b0 && rd_q.size() > 0) chk(rdat, rd_q.pop_front());
    if (wsw === 1'b1) chk({16'h0, win},
                          win_q.size() > 0 ? {16'h0, win_q.pop_front()} : 32'hFFFFFFFF);
    if (rpr === 1'b1) chk({16'h0, rwin},
                          rpt_q.size() > 0 ? {16'h0, rpt_q.pop_front()} : 32'hFFFFFFFF);
    if (hc === 1'b1) hc_cnt++;
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic [15:0] cst, pst, m;
    logic [15:0] src [4];
    logic [15:0] bits [6];
    logic [1:0] exp [6];
    int cnt;
    logic rcp, to_ctl;
    void'($urandom(32'hd82aea82));
    // per step: backlight expected, control bits kept
    bits = '{16'h1, 16'h0, 16'h4, 16'h0, 16'h2, 16'h8};
    exp = '{2'b01, 2'b00, 2'b11, 2'b10, 2'b00, 2'b10};
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd_chk(plc_ctrl_pkg::OFS_STATUS, 32'h1);
    wr_reg(6'h3C, 16'h1234);
    rd_chk(6'h3C, 32'h0);
    win_q.push_back(16'h0004);
    wr_reg(plc_ctrl_pkg::OFS_WIN_SEL, 16'h0004);
    rd_chk(plc_ctrl_pkg::OFS_WIN_ECHO, 32'h4);
    rd_chk(plc_ctrl_pkg::OFS_BASE_WIN, 32'h4);
    wr_reg(plc_ctrl_pkg::OFS_WIN_SEL, 16'h0004);
    wr_reg(plc_ctrl_pkg::OFS_WIN_SEL, 16'(NW));
    rd_chk(plc_ctrl_pkg::OFS_WIN_ECHO, 32'h4);
    win_q.push_back(16'(NW - 1));
    wr_reg(plc_ctrl_pkg::OFS_WIN_SEL, 16'(NW - 1));
    rd_chk(plc_ctrl_pkg::OFS_WIN_ECHO, 32'(NW - 1));
    rpt_q.push_back(16'h0009);
    wr_reg(plc_ctrl_pkg::OFS_RPT_PRINT, 16'h0009);
    wr_reg(plc_ctrl_pkg::OFS_RPT_PRINT, 16'(NW));
    chk({16'h0, win}, 32'(NW - 1));
    // block transfers in all four directions
    wr_reg(plc_ctrl_pkg::OFS_XFER_BASE, 16'h0020);
    for (int md = 1; md <= 4; md++) begin
      cnt = $urandom_range(1, 4);
      m = 16'($urandom_range(0, 40));
      pst = 16'($urandom_range(0, 200));
      cst = 16'h0024 + m;
      rcp = (md == 1 || md == 3);
      to_ctl = (md >= 3);
      for (int i = 0; i < cnt; i++) begin
        src[i] = 16'($urandom);
        if (to_ctl) i_sto.mem[{rcp, pst[7:0] + 8'(i)}] = src[i];
        else i_ctl.mem[{1'b0, cst[7:0] + 8'(i)}] = src[i];
      end
      wr_reg(plc_ctrl_pkg::OFS_XFER_COUNT, 16'(cnt));
      wr_reg(plc_ctrl_pkg::OFS_XFER_CTL_OFS, m);
      wr_reg(plc_ctrl_pkg::OFS_XFER_PNL_OFS, pst);
      wr_reg(plc_ctrl_pkg::OFS_XFER_MODE, 16'(md));
      q = 32'hFFFF;
      for (int n = 0; n < 60 && q[15:0] !== 16'h0; n++) bus(1'b0, 6'h10, 32'h0, q);
      chk(q, 32'h0);
      if (q[15:0] !== 16'h0) final_report();
      for (int i = 0; i < cnt; i++) begin
        chk(to_ctl ? i_ctl.mem[{1'b0, cst[7:0] + 8'(i)}]
                   : i_sto.mem[{rcp, pst[7:0] + 8'(i)}], src[i]);
      end
    end
    // unknown mode code is kept and starts nothing
    wr_reg(plc_ctrl_pkg::OFS_XFER_MODE, 16'h0005);
    rd_chk(plc_ctrl_pkg::OFS_XFER_MODE, 32'h5);
    rd_chk(plc_ctrl_pkg::OFS_STATUS, 32'h1);
    // backlight off/on, plain and self-clearing
    for (int k = 0; k < 6; k++) begin
      wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, bits[k]);
      repeat (3) @(posedge clock_i);
      rd_chk(plc_ctrl_pkg::OFS_STATUS, {31'h0, exp[k][1]});
      rd_chk(plc_ctrl_pkg::OFS_CTRL_BITS, exp[k][0] ? {16'h0, bits[k]} : 32'h0);
    end
    // hardcopy on rising control bit only
    wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, 16'h0010);
    wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, 16'h0010);
    repeat (3) @(posedge clock_i);
    chk(hc_cnt, 32'h1);
    wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, 16'h0000);
    wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, 16'h0010);
    repeat (3) @(posedge clock_i);
    chk(hc_cnt, 32'h2);
    // macro runs while its bit is one
    m = 16'($urandom);
    wr_reg(plc_ctrl_pkg::OFS_MACRO_NUM, m);
    wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, 16'h0020);
    repeat (3) @(posedge clock_i);
    chk({15'h0, mrun, mnum}, {15'h0, 1'b1, m});
    wr_reg(plc_ctrl_pkg::OFS_CTRL_BITS, 16'h0000);
    repeat (3) @(posedge clock_i);
    chk({31'h0, mrun}, 32'h0);
    chk(32'(win_q.size() + rpt_q.size() + rd_q.size()), 32'h0);
    final_report();
  end
endmodule // plc_register_control_engine_tb
`default_nettype wire
